// *** hpsic_top.sv ***
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hpsic_defines.svh"

// Notes on behaviour
// - attention field bits 7:6; every write sends an attention message
// - power indicator bits 9:8, codes on/blink/off, resets to off
// - every power indicator write sends a power indicator message
// - bit 10 controls slot power: 0 on, 1 off; resets to 0
// - when enabled, link-active changes notify software
module hpsic_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic link_active_i,
  output hpsic_pkg::hpsic_msg_t attn_msg_o,
  output hpsic_pkg::hpsic_msg_t pwr_msg_o,
  output logic [1:0] attn_ind_o,
  output logic [1:0] pwr_ind_o,
  output logic slot_pwr_off_o,
  output logic irq_o
);
  import hpsic_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic pctl;
  logic dll_en;
  logic [2:0] stat;
  logic [2:0] mask;
  logic link_q;
  logic [1:0] attn_f;
  logic [1:0] pwr_f;
  hpsic_msg_t attn_m;
  hpsic_msg_t pwr_m;

  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i;
  wire sel_ctrl = adr_i == `HPSIC_ADDR_CTRL;
  wire sel_stat = adr_i == `HPSIC_ADDR_STAT;
  wire sel_mask = adr_i == `HPSIC_ADDR_MASK;
  wire sel_link = adr_i == `HPSIC_ADDR_LINK;
  // byte lane 0 holds bits 7:6, lane 1 holds bits 12:8
  wire wr_b0 = wr & sel_ctrl & sel_i[0];
  wire wr_b1 = wr & sel_ctrl & sel_i[1];
  wire link_chg = link_q ^ link_active_i;

  function automatic logic [31:0] ctrl_word(input logic [1:0] a, input logic [1:0] p,
                                            input logic c, input logic d);
    ctrl_word = 32'h0;
    ctrl_word[`HPSIC_ATTN_HI:`HPSIC_ATTN_LO] = a;
    ctrl_word[`HPSIC_PWR_HI:`HPSIC_PWR_LO] = p;
    ctrl_word[`HPSIC_PCTL_BIT] = c;
    ctrl_word[`HPSIC_RSVD_BIT] = 1'b0;
    ctrl_word[`HPSIC_DLL_EN_BIT] = d;
  endfunction : ctrl_word

  wire [31:0] next_rdat = sel_ctrl ? ctrl_word(attn_f, pwr_f, pctl, dll_en) :
                          sel_stat ? {29'h0, stat} :
                          sel_mask ? {29'h0, mask} :
                          sel_link ? {31'h0, link_q} : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // indicator fields
  // attention write and message
  hpsic_msg_reg u_attn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_b0),
    .wdat_i(dat_i[`HPSIC_ATTN_HI:`HPSIC_ATTN_LO]),
    .field_o(attn_f),
    .msg_o(attn_m)
  );

  hpsic_msg_reg u_pwr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_b1),
    .wdat_i(dat_i[`HPSIC_PWR_HI:`HPSIC_PWR_LO]),
    .field_o(pwr_f),
    .msg_o(pwr_m)
  );

  wire [2:0] ev = {link_chg & dll_en, pwr_m.valid, attn_m.valid};
  wire [2:0] clr = (wr & sel_stat & sel_i[0]) ? dat_i[2:0] : 3'h0;
  wire mask_wr = wr & sel_mask & sel_i[0];
  logic [2:0] next_stat;
  logic [2:0] next_mask;

  // per status bit: an event in the clear cycle keeps the bit, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stat
      assign next_stat[gi] = ev[gi] | (stat[gi] & ~clr[gi]);
    end
  endgenerate

  // irq uses the next mask too, so a mask write never leaves a stale interrupt cycle
  assign next_mask = mask_wr ? dat_i[2:0] : mask;

  ////////////////////////////////////////////////////////////////////////
  // control and status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      pctl <= `HPSIC_PCTL_RST;
      dll_en <= `HPSIC_DLL_EN_RST;
      stat <= 3'h0;
      mask <= 3'h0;
      link_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      ack_o <= req;
      dat_o <= req ? next_rdat : 32'h0;
      if (wr_b1) begin
        pctl <= dat_i[`HPSIC_PCTL_BIT];
        dll_en <= dat_i[`HPSIC_DLL_EN_BIT];
      end
      mask <= next_mask;
      link_q <= link_active_i;
      // link change sets status only while dll_en is 1; set beats clear
      stat <= next_stat;
      irq_o <= |(next_stat & next_mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attn_msg_o <= '0;
      pwr_msg_o <= '0;
      attn_ind_o <= `HPSIC_ATTN_RST;
      pwr_ind_o <= `HPSIC_PWR_RST;
      slot_pwr_off_o <= 1'b0;
    end else begin
      attn_msg_o <= attn_m;
      pwr_msg_o <= pwr_m;
      attn_ind_o <= attn_f;
      pwr_ind_o <= pwr_f;
      slot_pwr_off_o <= pctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_attn_msg_sent: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b0 |-> ##2 attn_msg_o.valid && attn_msg_o.code == $past(dat_i[7:6], 2))
    else $error("attention message missing");
  a_pwr_reset_off: assert property (@(posedge clk_i)
    rst_i |=> pwr_ind_o == `HPSIC_PWR_RST)
    else $error("power indicator reset wrong");
  a_pwr_msg_sent: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b1 |-> ##2 pwr_msg_o.valid && pwr_msg_o.code == $past(dat_i[9:8], 2))
    else $error("power message missing");
  a_pwr_ctl_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b1 |-> ##2 slot_pwr_off_o == $past(dat_i[10], 2))
    else $error("slot power not following write");
  a_link_notify: assert property (@(posedge clk_i) disable iff (rst_i)
    (dll_en && link_chg) |=> stat[2])
    else $error("link change not flagged");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(sel_ctrl)) |-> dat_o[11] == 1'b0)
    else $error("reserved bit read nonzero");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held too long");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    |(stat & mask) |-> irq_o)
    else $error("irq not raised");

  // bus handshake and read data
  a_ack_on_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged");

  a_ack_no_req: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");

  a_rdat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");

  a_rdat_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !(sel_ctrl || sel_stat || sel_mask || sel_link)) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");

  a_ctrl_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(sel_ctrl)) |-> dat_o[31:13] == 19'h0 && dat_o[5:0] == 6'h0)
    else $error("unused control bits read nonzero");

  // attention indicator and message
  a_attn_ind_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b0 |-> ##2 attn_ind_o == $past(dat_i[7:6], 2))
    else $error("attention indicator not following write");

  a_attn_msg_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    attn_msg_o.valid |-> $past(wr_b0, 2))
    else $error("attention message without write");

  a_attn_ind_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(wr_b0, 2)) |-> $stable(attn_ind_o))
    else $error("attention indicator changed without write");

  a_attn_msg_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    attn_msg_o.valid |=> !attn_msg_o.valid)
    else $error("attention message longer than a cycle");

  a_msg_code_attn: assert property (@(posedge clk_i) disable iff (rst_i)
    attn_msg_o.valid |-> attn_msg_o.code == attn_ind_o)
    else $error("attention message code differs from field");

  a_stat_ev_attn: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b0 |-> ##2 stat[0])
    else $error("attention message not flagged");

  // power indicator and message
  a_pwr_ind_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b1 |-> ##2 pwr_ind_o == $past(dat_i[9:8], 2))
    else $error("power indicator not following write");

  a_pwr_ind_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(wr_b1, 2)) |-> $stable(pwr_ind_o))
    else $error("power indicator changed without write");

  a_pwr_msg_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_msg_o.valid |-> $past(wr_b1, 2))
    else $error("power message without write");

  a_pwr_msg_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_msg_o.valid |=> !pwr_msg_o.valid)
    else $error("power message longer than a cycle");

  a_msg_code_pwr: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_msg_o.valid |-> pwr_msg_o.code == pwr_ind_o)
    else $error("power message code differs from field");

  a_stat_ev_pwr: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b1 |-> ##2 stat[1])
    else $error("power message not flagged");

  // slot power; the output trails the field by one register
  a_pwr_off_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(wr_b1, 2)) |-> $stable(slot_pwr_off_o))
    else $error("slot power changed without write");

  // link-active notification
  a_link_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(dll_en && link_chg) && !stat[2]) |=> !stat[2])
    else $error("link flag set without enabled change");

  a_link_track: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> link_q == $past(link_active_i))
    else $error("link state not tracked");

  a_dll_en_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b1 |=> dll_en == $past(dat_i[12]))
    else $error("link notify enable not written");

  // status, mask and interrupt
  a_irq_exact: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(stat & mask))
    else $error("irq differs from masked status");

  a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && sel_stat && sel_i[0]) |=> (stat & $past(dat_i[2:0] & ~ev)) == 3'h0)
    else $error("status bit not cleared");

  a_stat_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    |ev |=> (stat & $past(ev)) == $past(ev))
    else $error("status event lost");

  a_stat_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && sel_stat) |=> (stat & $past(stat)) == $past(stat))
    else $error("status bit dropped without clear");

  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && sel_mask && sel_i[0]) |=> mask == $past(dat_i[2:0]))
    else $error("mask not written");

  a_mask_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && sel_mask) |=> $stable(mask))
    else $error("mask changed without write");

  // reset values
  a_ind_reset: assert property (@(posedge clk_i)
    rst_i |=> attn_ind_o == `HPSIC_ATTN_RST && pwr_ind_o == `HPSIC_PWR_RST && !slot_pwr_off_o)
    else $error("indicator outputs not at reset value");

  a_bus_reset: assert property (@(posedge clk_i)
    rst_i |=> !ack_o && dat_o == 32'h0 && !irq_o && !attn_msg_o.valid && !pwr_msg_o.valid)
    else $error("bus outputs not at reset value");

endmodule : hpsic_top
`default_nettype wire

// *** hpsic_defines.svh ***
`ifndef HPSIC_DEFINES_SVH
`define HPSIC_DEFINES_SVH

// register byte addresses
`define HPSIC_ADDR_CTRL 4'h0
`define HPSIC_ADDR_STAT 4'h4
`define HPSIC_ADDR_MASK 4'h8
`define HPSIC_ADDR_LINK 4'hc

// slot control field positions
`define HPSIC_DLL_EN_BIT 12
`define HPSIC_ATTN_LO 6
`define HPSIC_ATTN_HI 7
`define HPSIC_PWR_LO 8
`define HPSIC_PWR_HI 9
`define HPSIC_PCTL_BIT 10
`define HPSIC_RSVD_BIT 11

// reset values
`define HPSIC_ATTN_RST 2'h3
`define HPSIC_PWR_RST 2'h3
`define HPSIC_PCTL_RST 1'h0
`define HPSIC_DLL_EN_RST 1'h0

// status bits
`define HPSIC_ST_ATTN 0
`define HPSIC_ST_PWR 1
`define HPSIC_ST_LINK 2
`define HPSIC_ST_W 3

`endif

// *** hpsic_pkg.sv ***
package hpsic_pkg;
  typedef struct packed {
    logic valid;
    logic [1:0] code;
  } hpsic_msg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } hpsic_wb_req_t;
endpackage : hpsic_pkg

// *** hpsic_msg_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hpsic_defines.svh"

// one indicator field plus its message strobe
module hpsic_msg_reg (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] wdat_i,
  output logic [1:0] field_o,
  output hpsic_pkg::hpsic_msg_t msg_o
);
  import hpsic_pkg::*;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      field_o <= `HPSIC_ATTN_RST;
      msg_o <= '0;
    end else begin
      msg_o.valid <= wr_i;
      if (wr_i) begin
        field_o <= wdat_i;
        msg_o.code <= wdat_i;
      end
    end
  end
endmodule : hpsic_msg_reg
`default_nettype wire

// *** hpsic_slot_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// slot side: shows the last indicator codes, link is up while the slot is powered
module hpsic_slot_model (
  input wire logic clk_i,
  input wire hpsic_pkg::hpsic_msg_t attn_msg_i,
  input wire hpsic_pkg::hpsic_msg_t pwr_msg_i,
  input wire logic slot_pwr_off_i,
  output logic [1:0] attn_shown_o,
  output logic [1:0] pwr_shown_o,
  output logic [7:0] n_msg_o,
  output logic link_active_o
);
  import hpsic_pkg::*;
  initial begin
    attn_shown_o = 2'h0;
    pwr_shown_o = 2'h0;
    n_msg_o = 8'h0;
    link_active_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (attn_msg_i.valid) attn_shown_o <= attn_msg_i.code;
    if (pwr_msg_i.valid) pwr_shown_o <= pwr_msg_i.code;
    n_msg_o <= n_msg_o + 8'(attn_msg_i.valid === 1'b1) + 8'(pwr_msg_i.valid === 1'b1);
    link_active_o <= !slot_pwr_off_i;
  end
endmodule : hpsic_slot_model
`default_nettype wire

// *** tb_hot_plug_slot_indicator_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_hot_plug_slot_indicator_control;
  import hpsic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  wire logic [31:0] dout;
  wire logic ack, link, pwr_off, irq;
  wire logic [1:0] attn_ind, pwr_ind, attn_seen, pwr_seen;
  wire logic [7:0] n_msg;
  hpsic_msg_t attn_msg, pwr_msg;
  int fails = 0, n_checks = 0, cyc_cnt = 0;
  logic [7:0] n0;
  hpsic_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dout), .ack_o(ack),
    .link_active_i(link), .attn_msg_o(attn_msg), .pwr_msg_o(pwr_msg),
    .attn_ind_o(attn_ind), .pwr_ind_o(pwr_ind), .slot_pwr_off_o(pwr_off), .irq_o(irq));
  hpsic_slot_model slot (.clk_i(clk_i), .attn_msg_i(attn_msg), .pwr_msg_i(pwr_msg),
    .slot_pwr_off_i(pwr_off), .attn_shown_o(attn_seen), .pwr_shown_o(pwr_seen),
    .n_msg_o(n_msg), .link_active_o(link));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic wrap_up;
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp || $isunknown(got)) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // one classic cycle; waits for ack, then releases for a cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic t_reset;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    chk("ctrl_rst", 32'h3c0, rd);
    chk("pwr_off_rst", 32'h0, {31'h0, pwr_off});
    chk("ind_rst", 32'hf, {28'h0, attn_ind, pwr_ind});
    wb(1'b0, 4'h2, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_reset
  task automatic t_ind;
    for (int c = 1; c < 4; c++) begin
      wb(1'b1, 4'h0, 4'h1, 32'(c) << 6);
      wb(1'b1, 4'h0, 4'h2, 32'(c) << 8);
      repeat (2) @(posedge clk_i);
      chk("attn_seen", 32'(c), {30'h0, attn_seen});
      chk("pwr_seen", 32'(c), {30'h0, pwr_seen});
      chk("attn_ind", 32'(c), {30'h0, attn_ind});
      chk("pwr_ind", 32'(c), {30'h0, pwr_ind});
      wb(1'b0, 4'h0, 4'hf, 32'h0);
      chk("ctrl_rb", (32'(c) << 6) | (32'(c) << 8), rd);
    end
    n0 = n_msg;
    wb(1'b1, 4'h0, 4'h3, 32'h0bc0);
    wb(1'b1, 4'h0, 4'h3, 32'h0bc0);
    repeat (3) @(posedge clk_i);
    chk("n_msg", 32'(n0) + 32'h4, 32'(n_msg));
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    chk("rsvd", 32'h3c0, rd);
  endtask : t_ind
  task automatic t_link;
    wb(1'b1, 4'h4, 4'hf, 32'h7);
    wb(1'b1, 4'h8, 4'hf, 32'h4);
    wb(1'b1, 4'h0, 4'h2, 32'h1700);
    repeat (6) @(posedge clk_i);
    chk("pwr_off", 32'h1, {31'h0, pwr_off});
    wb(1'b0, 4'h4, 4'hf, 32'h0);
    chk("stat", 32'h6, rd);
    chk("irq_set", 32'h1, {31'h0, irq});
    wb(1'b1, 4'h4, 4'hf, 32'h4);
    repeat (3) @(posedge clk_i);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wb(1'b1, 4'h0, 4'h2, 32'h0300);
    repeat (3) @(posedge clk_i);
    chk("pwr_on", 32'h0, {31'h0, pwr_off});
  endtask : t_link
  initial begin
    t_reset();
    t_ind();
    t_link();
    wrap_up();
  end
endmodule : tb_hot_plug_slot_indicator_control
`default_nettype wire
